//--- rtl/bra_debounce.sv
/*
 * bra_debounce: contact-bounce filter for the abort pushbutton; gives one
 * pulse on the filtered press edge.
 * assumes raw_n is already synchronous to pclk, low while pressed.
 */
`timescale 1ns/1ps

module bra_debounce (
    input  wire logic pclk,
    input  wire logic presetn,
    bra_filter_if.filter fif
);

    typedef struct packed {
        logic [15:0] count;
        logic        last_raw;
        logic        stable;
        logic        pulse;
    } bra_deb_state_type;

    bra_deb_state_type state_reg;
    bra_deb_state_type state_next;

    // ****************************************************************
    // filter
    // ****************************************************************
    always_comb begin
        state_next          = state_reg;
        state_next.pulse    = 1'b0;
        state_next.last_raw = ~fif.raw_n;
        if (~fif.raw_n != state_reg.last_raw) begin
            state_next.count = 16'h0000;
        end else if (state_reg.count < fif.stable_cycles) begin
            state_next.count = state_reg.count + 16'h0001;
        end else if (state_reg.stable != state_reg.last_raw) begin
            // only the stable rising edge counts, bounce never reaches here
            state_next.stable = state_reg.last_raw;
            state_next.pulse  = state_reg.last_raw;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign fif.stable_level = state_reg.stable;
    assign fif.press_pulse  = state_reg.pulse;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_one_pulse;
        @(posedge pclk) disable iff (!presetn)
        state_reg.pulse |=> !state_reg.pulse;
    endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("press pulse longer than one cycle");

    property p_pulse_needs_stable;
        @(posedge pclk) disable iff (!presetn)
        state_reg.pulse |-> $past(state_reg.count) >= $past(fif.stable_cycles);
    endproperty
    a_pulse_needs_stable: assert property (p_pulse_needs_stable)
        else $error("press accepted before input settled");

endmodule

//--- rtl/bra_filter_if.sv
/*
 * bra_filter_if: carries the abort switch filter's settings and result
 * between the top module and its debounce filter.
 * assumes one clock domain, pclk.
 */
`timescale 1ns/1ps

interface bra_filter_if;
    logic [15:0] stable_cycles;
    logic        raw_n;
    logic        stable_level;
    logic        press_pulse;

    modport top (
        output stable_cycles,
        output raw_n,
        input  stable_level,
        input  press_pulse
    );
    modport filter (
        input  stable_cycles,
        input  raw_n,
        output stable_level,
        output press_pulse
    );
endinterface

//--- rtl/bra_pkg.sv
/*
 * bra_pkg: register offsets, field positions, reset values and timing counts
 * for the board reset, abort and indicator block.
 * assumes a 25 MHz pclk and a 32-bit apb master.
 */
package bra_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned SYSRST_MIN_MS   = 200;
    // least time; CLK_HZ/1000 truncates, exact at 25 MHz
    localparam int unsigned SYSRST_CYC      = (CLK_HZ / 1000) * SYSRST_MIN_MS;
    localparam int unsigned LAMP_MIN_MS     = 50;
    localparam int unsigned LAMP_CYC        = (CLK_HZ / 1000) * LAMP_MIN_MS;
    localparam int unsigned ABORT_LEVEL_IRQ = 8;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_MISC_CONTROL_REG  = 8'h00;
    localparam logic [7:0] ADDR_ABORT_CTL = 8'h04;
    localparam logic [7:0] ADDR_DEBOUNCE  = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0c;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned MISC_SYS_SW   = 0;
    localparam int unsigned MISC_LOCAL_SW = 1;
    localparam int unsigned ABT_ENABLE    = 0;
    localparam int unsigned ABT_LEVEL_LSB = 4;
    localparam int unsigned ABT_LEVEL_W   = 3;
    localparam int unsigned ST_PENDING    = 0;
    localparam int unsigned ST_SYSCON     = 1;
    localparam int unsigned ST_SYSRST_OUT = 2;
    localparam int unsigned ST_LOCAL_RST  = 3;
    localparam int unsigned ST_SW_STABLE  = 4;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [1:0]  MISC_RESET  = 2'h0;
    localparam logic [2:0]  LEVEL_RESET = 3'h7;
    localparam logic [15:0] DEB_RESET   = 16'h61a8;

    typedef enum logic [1:0] {
        SR_IDLE,
        SR_HOLD,
        SR_WAIT_RELEASE
    } bra_sysrst_state_type;

endpackage

//--- rtl/bra_top.sv
/*
 * bra_top: board reset, abort interrupt and front panel lamp logic with an
 * apb register slave.
 * assumes all pin inputs synchronous to pclk; active-low pins carry _n.
 */
// The implementer's own choices: the placing of the registers and register access over APB.
// Operation
// - abort press interrupts only when enabled, at a software-set level
// - abort interrupt on isa irq line 8 and on a status io port bit
// - abort detected on a filtered edge, one event per press
// - reset button resets the board and, as controller, the backplane
// - as controller, sysreset from button, power-up, watchdog or software bit
// - backplane sysreset held at least 200 ms each time
// - local reset from button, power-up, watchdog, sysreset in or software bit
// - local reset works whether or not this board is controller
// - local reset holds while software keeps its control bit set
// - halt lamp lights on processor halt status
// - board fault lamp lights while board fault line is low
// - processor lamp lights while data bus busy is active
// - pci lamp lights while irdy is asserted
// - controller lamp lights while this board is system controller
`timescale 1ns/1ps

module bra_top #(
    parameter int unsigned SYSRST_CYCLES = bra_pkg::SYSRST_CYC,
    parameter int unsigned LAMP_CYCLES   = bra_pkg::LAMP_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        abort_button_n,
    input  wire logic        reset_button_n,
    input  wire logic        power_up_reset_n,
    input  wire logic        watchdog_reset_n,
    input  wire logic        sysreset_in_n,
    input  wire logic        system_controller,
    input  wire logic        cpu_halt,
    input  wire logic        board_fault_n,
    input  wire logic        data_bus_busy_n,
    input  wire logic        pci_irdy_n,
    output logic             isa_irq8_n,
    output logic [2:0]       abort_irq_level,
    output logic             status_io_port_bit,
    output logic             sysreset_out,
    output logic             sysreset_oe,
    output logic             local_reset_n,
    output logic             halt_indicator_lamp,
    output logic             board_fault_lamp,
    output logic             cpu_activity_lamp,
    output logic             pci_activity_lamp,
    output logic             controller_role_lamp
);

    typedef struct packed {
        logic [1:0]                 misc_control_reg;
        logic                       abort_enable;
        logic [2:0]                 abort_level;
        logic [15:0]                debounce_cycles;
        logic                       abort_pending;
        bra_pkg::bra_sysrst_state_type sr_state;
        logic [31:0]                sr_count;
        logic [31:0]                cpu_count;
        logic [31:0]                pci_count;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
        logic                       irq_n;
        logic                       io_bit;
        logic                       sysrst;
        logic                       local_n;
        logic [4:0]                 lamps;
    } bra_top_state_type;

    bra_top_state_type state_reg;
    bra_top_state_type state_next;
    bra_filter_if      fif ();

    assign fif.stable_cycles = state_reg.debounce_cycles;
    assign fif.raw_n         = abort_button_n;

    bra_debounce u_debounce (
        .pclk    (pclk),
        .presetn (presetn),
        .fif     (fif)
    );

    // stretch counter: reload on activity, count down to zero
    function automatic logic [31:0] stretch(input logic active, input logic [31:0] cnt);
        if (active) begin
            return LAMP_CYCLES;
        end
        return (cnt != 32'h0) ? cnt - 32'h1 : 32'h0;
    endfunction

    logic global_cause;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_next         = state_reg;
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;
        // causes that reach the backplane, only used as controller
        global_cause = ~reset_button_n | ~power_up_reset_n | ~watchdog_reset_n
                     | state_reg.misc_control_reg[bra_pkg::MISC_SYS_SW];

        // apb slave: answer in the cycle after setup, no wait states
        if (psel && !penable) begin
            state_next.pready = 1'b1;
            state_next.prdata = 32'h0;
            case (paddr)
                bra_pkg::ADDR_MISC_CONTROL_REG: begin
                    state_next.prdata[1:0] = state_reg.misc_control_reg;
                end
                bra_pkg::ADDR_ABORT_CTL: begin
                    state_next.prdata[bra_pkg::ABT_ENABLE] = state_reg.abort_enable;
                    state_next.prdata[bra_pkg::ABT_LEVEL_LSB +: bra_pkg::ABT_LEVEL_W] =
                        state_reg.abort_level;
                end
                bra_pkg::ADDR_DEBOUNCE: begin
                    state_next.prdata[15:0] = state_reg.debounce_cycles;
                end
                bra_pkg::ADDR_STATUS: begin
                    state_next.prdata[bra_pkg::ST_PENDING]    = state_reg.abort_pending;
                    state_next.prdata[bra_pkg::ST_SYSCON]     = system_controller;
                    state_next.prdata[bra_pkg::ST_SYSRST_OUT] = state_reg.sysrst;
                    state_next.prdata[bra_pkg::ST_LOCAL_RST]  = ~state_reg.local_n;
                    state_next.prdata[bra_pkg::ST_SW_STABLE]  = fif.stable_level;
                end
                default: begin
                    state_next.pslverr = 1'b1;
                end
            endcase
        end

        // writes take effect at the access edge
        if (psel && penable && pwrite && state_reg.pready && !state_reg.pslverr) begin
            case (paddr)
                bra_pkg::ADDR_MISC_CONTROL_REG: begin
                    state_next.misc_control_reg = pwdata[1:0];
                end
                bra_pkg::ADDR_ABORT_CTL: begin
                    state_next.abort_enable = pwdata[bra_pkg::ABT_ENABLE];
                    state_next.abort_level  =
                        pwdata[bra_pkg::ABT_LEVEL_LSB +: bra_pkg::ABT_LEVEL_W];
                end
                bra_pkg::ADDR_DEBOUNCE: begin
                    state_next.debounce_cycles = pwdata[15:0];
                end
                bra_pkg::ADDR_STATUS: begin
                    // write one to acknowledge the abort event
                    if (pwdata[bra_pkg::ST_PENDING]) begin
                        state_next.abort_pending = 1'b0;
                    end
                end
                default: begin
                    state_next.pslverr = 1'b0;
                end
            endcase
        end

        // set beats acknowledge in the same cycle
        if (fif.press_pulse && state_reg.abort_enable) begin
            state_next.abort_pending = 1'b1;
        end
        state_next.irq_n = ~state_reg.abort_pending;
        state_next.io_bit = state_reg.abort_pending;

        // backplane reset: pulse stretched to the minimum, released once causes end
        case (state_reg.sr_state)
            bra_pkg::SR_IDLE: begin
                if (global_cause && system_controller) begin
                    state_next.sr_state = bra_pkg::SR_HOLD;
                    state_next.sr_count = 32'h0;
                    state_next.sysrst   = 1'b1;
                end
            end
            bra_pkg::SR_HOLD: begin
                state_next.sr_count = state_reg.sr_count + 32'h1;
                if (state_reg.sr_count >= SYSRST_CYCLES - 2) begin
                    state_next.sr_state = bra_pkg::SR_WAIT_RELEASE;
                end
            end
            bra_pkg::SR_WAIT_RELEASE: begin
                if (!global_cause || !system_controller) begin
                    state_next.sr_state = bra_pkg::SR_IDLE;
                    state_next.sysrst   = 1'b0;
                end
            end
            default: begin
                state_next.sr_state = bra_pkg::SR_IDLE;
                state_next.sysrst   = 1'b0;
            end
        endcase

        // local reset regardless of controller role
        state_next.local_n = ~(~reset_button_n | ~power_up_reset_n | ~watchdog_reset_n
                             | ~sysreset_in_n
                             | state_reg.misc_control_reg[bra_pkg::MISC_LOCAL_SW]);

        state_next.cpu_count = stretch(~data_bus_busy_n, state_reg.cpu_count);
        state_next.pci_count = stretch(~pci_irdy_n, state_reg.pci_count);
        state_next.lamps[0]  = cpu_halt;
        state_next.lamps[1]  = ~board_fault_n;
        state_next.lamps[2]  = ~data_bus_busy_n | (state_reg.cpu_count != 32'h0);
        state_next.lamps[3]  = ~pci_irdy_n | (state_reg.pci_count != 32'h0);
        state_next.lamps[4]  = system_controller;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg                  <= '0;
            state_reg.abort_level      <= bra_pkg::LEVEL_RESET;
            state_reg.debounce_cycles  <= bra_pkg::DEB_RESET;
            state_reg.misc_control_reg <= bra_pkg::MISC_RESET;
            state_reg.sr_state         <= bra_pkg::SR_IDLE;
            state_reg.irq_n            <= 1'b1;
            state_reg.local_n          <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata               = state_reg.prdata;
    assign pready               = state_reg.pready;
    assign pslverr              = state_reg.pslverr;
    assign isa_irq8_n           = state_reg.irq_n;
    assign status_io_port_bit   = state_reg.io_bit;
    assign abort_irq_level      = state_reg.abort_level;
    assign sysreset_out         = 1'b0;
    assign sysreset_oe          = state_reg.sysrst;
    assign local_reset_n        = state_reg.local_n;
    assign halt_indicator_lamp  = state_reg.lamps[0];
    assign board_fault_lamp     = state_reg.lamps[1];
    assign cpu_activity_lamp    = state_reg.lamps[2];
    assign pci_activity_lamp    = state_reg.lamps[3];
    assign controller_role_lamp = state_reg.lamps[4];

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [31:0] sr_on_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_on_cnt <= 32'h0;
        end else begin
            sr_on_cnt <= state_reg.sysrst ? sr_on_cnt + 32'h1 : 32'h0;
        end
    end

    property p_sysrst_min;
        @(posedge pclk) disable iff (!presetn)
        $fell(state_reg.sysrst) |-> sr_on_cnt >= SYSRST_CYCLES;
    endproperty
    a_sysrst_min: assert property (p_sysrst_min)
        else $error("backplane reset released too early");

    property p_sysrst_start;
        @(posedge pclk) disable iff (!presetn)
        (!reset_button_n && system_controller && state_reg.sr_state == bra_pkg::SR_IDLE)
            |=> state_reg.sysrst;
    endproperty
    a_sysrst_start: assert property (p_sysrst_start)
        else $error("reset button did not drive backplane reset");

    property p_no_sysrst_non_ctrl;
        @(posedge pclk) disable iff (!presetn)
        (!system_controller && state_reg.sr_state == bra_pkg::SR_IDLE)
            |=> (!state_reg.sysrst && state_reg.sr_state == bra_pkg::SR_IDLE);
    endproperty
    a_no_sysrst_non_ctrl: assert property (p_no_sysrst_non_ctrl)
        else $error("backplane reset driven while not controller");

    property p_local_sw;
        @(posedge pclk) disable iff (!presetn)
        state_reg.misc_control_reg[bra_pkg::MISC_LOCAL_SW] |=> !local_reset_n;
    endproperty
    a_local_sw: assert property (p_local_sw)
        else $error("local reset released while software holds it");

    property p_local_sysrst_in;
        @(posedge pclk) disable iff (!presetn)
        !sysreset_in_n |=> !local_reset_n;
    endproperty
    a_local_sysrst_in: assert property (p_local_sysrst_in)
        else $error("incoming backplane reset missed locally");

    property p_irq_needs_enable;
        @(posedge pclk) disable iff (!presetn)
        (fif.press_pulse && !state_reg.abort_enable && !state_reg.abort_pending)
            |=> !state_reg.abort_pending;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("abort interrupt raised while disabled");

    property p_irq_follows;
        @(posedge pclk) disable iff (!presetn)
        (fif.press_pulse && state_reg.abort_enable) |=> ##1 (!isa_irq8_n && status_io_port_bit);
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("abort interrupt not delivered");

    property p_lamp_stretch;
        @(posedge pclk) disable iff (!presetn)
        $rose(data_bus_busy_n) |=> cpu_activity_lamp [*2];
    endproperty
    a_lamp_stretch: assert property (p_lamp_stretch)
        else $error("processor lamp not stretched");

    property p_fault_lamp;
        @(posedge pclk) disable iff (!presetn)
        !board_fault_n |=> board_fault_lamp;
    endproperty
    a_fault_lamp: assert property (p_fault_lamp)
        else $error("board fault lamp dark during fault");

endmodule

//--- testbench/bra_backplane.sv
/*
 * bra_backplane: far-side model of the shared backplane reset line.
 * assumes other boards only ever pull the line low; a pull-up holds it high.
 */
`timescale 1ns/1ps

module bra_backplane (
    input  wire logic sysreset_oe,
    input  wire logic other_pull,
    output logic      sysreset_in_n
);
    // wired open drain: whoever pulls wins, released line floats up
    assign sysreset_in_n = !(sysreset_oe || other_pull);
endmodule

//--- testbench/testbench.sv
/*
 * testbench: apb driven checks of abort interrupt, reset sources and lamps.
 * assumes bra_top with short counts and the bra_backplane line model.
 */
`timescale 1ns/1ps

module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        abort_button_n = 1'b1, system_controller = 1'b0, other_pull = 1'b0;
    logic [2:0]  cause_n = 3'h7;
    logic        cpu_halt = 1'b0, board_fault_n = 1'b1;
    logic        data_bus_busy_n = 1'b1, pci_irdy_n = 1'b1;
    logic        isa_irq8_n, status_io_port_bit, sysreset_out, sysreset_oe;
    logic        sysreset_in_n, local_reset_n, halt_lamp, fault_lamp;
    logic        cpu_lamp, pci_lamp, role_lamp;
    logic [2:0]  abort_irq_level;
    int          mismatches = 0, tests_run = 0, cycles = 0;

    always #20 pclk = ~pclk;

    bra_top #(.SYSRST_CYCLES(20), .LAMP_CYCLES(4)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .abort_button_n(abort_button_n),
        .reset_button_n(cause_n[0]), .power_up_reset_n(cause_n[1]),
        .watchdog_reset_n(cause_n[2]), .sysreset_in_n(sysreset_in_n),
        .system_controller(system_controller), .cpu_halt(cpu_halt),
        .board_fault_n(board_fault_n), .data_bus_busy_n(data_bus_busy_n),
        .pci_irdy_n(pci_irdy_n), .isa_irq8_n(isa_irq8_n),
        .abort_irq_level(abort_irq_level), .status_io_port_bit(status_io_port_bit),
        .sysreset_out(sysreset_out), .sysreset_oe(sysreset_oe),
        .local_reset_n(local_reset_n), .halt_indicator_lamp(halt_lamp),
        .board_fault_lamp(fault_lamp), .cpu_activity_lamp(cpu_lamp),
        .pci_activity_lamp(pci_lamp), .controller_role_lamp(role_lamp));

    bra_backplane bus (.sysreset_oe(sysreset_oe), .other_pull(other_pull),
                       .sysreset_in_n(sysreset_in_n));

    // ****************************************************************
    // checking and apb tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // called just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, bra_pkg::ADDR_ABORT_CTL, 32'h0);
        check("abort ctl reset", 32'h70, rd);
        apb(1'b0, bra_pkg::ADDR_DEBOUNCE, 32'h0);
        check("debounce reset", 32'h61a8, rd);
        apb(1'b1, 8'h10, 32'h1);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, bra_pkg::ADDR_DEBOUNCE, 32'h4);
        for (int en = 1; en >= 0; en--) begin
            apb(1'b1, bra_pkg::ADDR_ABORT_CTL, 32'h30 | en);
            check("irq level", 32'h3, {29'h0, abort_irq_level});
            repeat (3) begin
                abort_button_n <= 1'b0;
                repeat (2) @(posedge pclk);
                abort_button_n <= 1'b1;
                repeat (2) @(posedge pclk);
            end
            check("irq after bounce", 32'h1, {31'h0, isa_irq8_n});
            abort_button_n <= 1'b0;
            repeat (20) @(posedge pclk);
            abort_button_n <= 1'b1;
            repeat (20) @(posedge pclk);
            check("irq after press", 32'h1 - en, {31'h0, isa_irq8_n});
            if (en == 1)
                check("io port bit", 32'h1, {31'h0, status_io_port_bit});
            apb(1'b1, bra_pkg::ADDR_STATUS, 32'h1);
            @(posedge pclk);
            check("irq after ack", 32'h1, {31'h0, isa_irq8_n});
            check("io bit after ack", 32'h0, {31'h0, status_io_port_bit});
        end
        // each controller cause: button, power-up, watchdog, software bit
        system_controller <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            if (c < 3)
                cause_n[c] <= 1'b0;
            else
                apb(1'b1, bra_pkg::ADDR_MISC_CONTROL_REG, 32'h1);
            repeat (2) @(posedge pclk);
            if (c < 3)
                cause_n[c] <= 1'b1;
            else
                apb(1'b1, bra_pkg::ADDR_MISC_CONTROL_REG, 32'h0);
            // late enough that an early release of the minimum hold shows
            repeat (14) @(posedge pclk);
            check("backplane drive", 32'h1, {31'h0, sysreset_oe});
            check("open drain level", 32'h0, {31'h0, sysreset_out});
            check("local by backplane", 32'h0, {31'h0, local_reset_n});
            repeat (16) @(posedge pclk);
            check("backplane freed", 32'h0, {31'h0, sysreset_oe});
            check("local freed", 32'h1, {31'h0, local_reset_n});
        end
        check("role lamp", 32'h1, {31'h0, role_lamp});
        system_controller <= 1'b0;
        cause_n[0] <= 1'b0;
        repeat (3) @(posedge pclk);
        check("no drive when not ctl", 32'h0, {31'h0, sysreset_oe});
        check("local by button", 32'h0, {31'h0, local_reset_n});
        cause_n[0] <= 1'b1;
        other_pull <= 1'b1;
        repeat (3) @(posedge pclk);
        check("local by other board", 32'h0, {31'h0, local_reset_n});
        other_pull <= 1'b0;
        apb(1'b1, bra_pkg::ADDR_MISC_CONTROL_REG, 32'h2);
        repeat (30) @(posedge pclk);
        check("local held by software", 32'h0, {31'h0, local_reset_n});
        apb(1'b1, bra_pkg::ADDR_MISC_CONTROL_REG, 32'h0);
        repeat (3) @(posedge pclk);
        check("local released", 32'h1, {31'h0, local_reset_n});
        check("role lamp off", 32'h0, {31'h0, role_lamp});
        // lamps: steady ones follow, one-cycle activity is stretched
        cpu_halt <= 1'b1;
        board_fault_n <= 1'b0;
        data_bus_busy_n <= 1'b0;
        pci_irdy_n <= 1'b0;
        @(posedge pclk);
        data_bus_busy_n <= 1'b1;
        pci_irdy_n <= 1'b1;
        repeat (3) @(posedge pclk);
        check("halt lamp", 32'h1, {31'h0, halt_lamp});
        check("fault lamp", 32'h1, {31'h0, fault_lamp});
        check("cpu lamp stretched", 32'h1, {31'h0, cpu_lamp});
        check("pci lamp stretched", 32'h1, {31'h0, pci_lamp});
        cpu_halt <= 1'b0;
        board_fault_n <= 1'b1;
        repeat (10) @(posedge pclk);
        check("halt lamp off", 32'h0, {31'h0, halt_lamp});
        check("fault lamp off", 32'h0, {31'h0, fault_lamp});
        check("cpu lamp off", 32'h0, {31'h0, cpu_lamp});
        check("pci lamp off", 32'h0, {31'h0, pci_lamp});
        print_verdict();
    end
endmodule
